// >>> eipl_cpu_model.sv
// Behavioural model of the CPU instruction sequencer
`timescale 1ns/1ns
module eipl_cpu_model
  import eipl_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Bench controls
  input  wire logic slow,
  input  wire logic return_from_interrupt_go,
  input  wire logic call_active,
  // Sequencer pulses
  output logic      insn_boundary,
  output logic      return_from_interrupt_done
);
  logic [3:0] cnt;
  logic       in_return_from_interrupt;
  // Last cycle of an instruction; nothing ends while the call runs
  assign insn_boundary = (cnt == 4'h0) && !call_active;
  assign return_from_interrupt_done     = insn_boundary && in_return_from_interrupt;
  // Slow mode issues divides, the longest instruction after a return
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= 4'h0;
      in_return_from_interrupt <= 1'b0;
    end else if (insn_boundary) begin
      in_return_from_interrupt <= return_from_interrupt_go;
      if (return_from_interrupt_go) cnt <= 4'(RETURN_FROM_INTERRUPT_CYCLES - 1);
      else cnt <= slow ? 4'(DIV_CYCLES - 1) : 4'h0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : eipl_cpu_model

// >>> eipl_ctrl.sv
// External interrupt conditioning and two-level priority sequencer
`timescale 1ns/1ns
module eipl_ctrl
  import eipl_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Special function register access
  input  wire eipl_sfr_t        sfr,
  output logic [7:0]            sfr_rdata,
  // Port pins as seen by the input buffers
  input  wire logic [7:0]       port_pins,
  // Pending requests of the other sources, bits 0 and 2 ignored
  input  wire logic [NUM_SRC-1:0] src_pending,
  // CPU sequencer
  input  wire logic             insn_boundary,
  input  wire logic             return_from_interrupt_done,
  output eipl_req_t             call_req,
  output logic                  call_active,
  output logic                  isr_enter
);

  // ==========================================================================
  // Lowest set bit of a request vector, fixed tie order
  function automatic logic [3:0] lowest_src(input logic [NUM_SRC-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : lowest_src

  // ==========================================================================
  // Register state
  logic [7:0] int_en_main, next_int_en_main;
  logic [7:0] int_prio_main, next_int_prio_main;
  logic [7:0] pin_cfg, next_pin_cfg;
  logic [7:0] int_en_ext, next_int_en_ext;
  logic [7:0] int_prio_ext, next_int_prio_ext;
  logic       ext_irq_zero_edge_select, next_edge0;
  logic       ext_irq_one_edge_select, next_edge1;
  logic       edge_flag0, next_edge_flag0;
  logic       edge_flag1, next_edge_flag1;
  logic       act_prev0, act_prev1;
  logic [7:0] next_rdata;

  // Conditioned inputs
  logic ext_irq_zero, ext_irq_one;
  logic ext_irq_zero_polarity, ext_irq_one_polarity;
  logic act0, act1;
  logic ext_irq_zero_pending, ext_irq_one_pending;

  // Pin selection is a plain read of the pad, so the crossbar owner of
  // that pin is never disturbed
  assign ext_irq_zero = port_pins[pin_cfg[CFG_PIN0_LSB +: 3]];
  assign ext_irq_one  = port_pins[pin_cfg[CFG_PIN1_LSB +: 3]];
  assign ext_irq_zero_polarity = pin_cfg[CFG_POL0_BIT];
  assign ext_irq_one_polarity  = pin_cfg[CFG_POL1_BIT];
  // Polarity 0 inverts so that active low reads as asserted
  assign act0 = ~(ext_irq_zero ^ ext_irq_zero_polarity);
  assign act1 = ~(ext_irq_one ^ ext_irq_one_polarity);

  // Level mode follows the input with no latch; edge mode shows the flag
  assign ext_irq_zero_pending = ext_irq_zero_edge_select ? edge_flag0
                                                         : act_prev0;
  assign ext_irq_one_pending  = ext_irq_one_edge_select ? edge_flag1
                                                        : act_prev1;

  // ==========================================================================
  // Arbitration, recomputed every cycle from the current pending set
  logic [NUM_SRC-1:0] enables, prios, pend, req, req_hi, req_lo;
  logic               in_high, in_low, return_from_interrupt_hold;
  logic               allow_hi, allow_lo;
  eipl_req_t          pick;

  always_comb begin
    enables = {int_en_ext, int_en_main[6:0]};
    prios   = {int_prio_ext, int_prio_main[6:0]};
    pend    = src_pending;
    pend[SRC_EXT0] = ext_irq_zero_pending;
    pend[SRC_EXT1] = ext_irq_one_pending;
    // Both the source enable and the global enable gate a request
    req    = pend & enables & {NUM_SRC{int_en_main[IE_GLOBAL_BIT]}};
    req_hi = req & prios;
    req_lo = req & ~prios;
    // High is never preempted; low only by high
    // A return holds entry off only until the boundary that ends the one
    // instruction after it; a longer hold would let two instructions run
    allow_hi = ~in_high & (~return_from_interrupt_hold | insn_boundary);
    allow_lo = ~in_high & ~in_low & (~return_from_interrupt_hold | insn_boundary);
    pick = '0;
    if (allow_hi && (|req_hi)) begin
      pick = '{valid: 1'b1, high: 1'b1, index: lowest_src(req_hi)};
    end else if (allow_lo && (|req_lo)) begin
      pick = '{valid: 1'b1, high: 1'b0, index: lowest_src(req_lo)};
    end
  end

  // ==========================================================================
  // Entry sequencer: detect, then a four-cycle long call
  eipl_state_t state, next_state;
  logic [1:0]  call_cnt, next_call_cnt;
  eipl_req_t   next_call_req;
  logic        next_in_high, next_in_low, next_return_from_interrupt_hold;

  assign call_active = (state == ST_CALL);
  assign isr_enter   = (state == ST_CALL) && (call_cnt == CALL_LAST);

  always_comb begin
    next_state     = state;
    next_call_cnt  = call_cnt;
    next_call_req  = call_req;
    next_in_high   = in_high;
    next_in_low    = in_low;
    next_return_from_interrupt_hold = return_from_interrupt_hold;
    // One instruction must finish after a return before the next call
    if (return_from_interrupt_done) begin
      next_return_from_interrupt_hold = 1'b1;
      if (in_high) begin
        next_in_high = 1'b0;
      end else begin
        next_in_low = 1'b0;
      end
    end else if (insn_boundary) begin
      next_return_from_interrupt_hold = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        // Taken only at an instruction boundary, so a divide after a
        // return stretches the response to its worst case
        if (insn_boundary && !return_from_interrupt_done && pick.valid) begin
          next_state    = ST_CALL;
          next_call_req = pick;
          next_call_cnt = 2'd0;
        end else begin
          next_call_req = '0;
        end
      end
      ST_CALL: begin
        next_call_cnt = call_cnt + 2'd1;
        if (call_cnt == CALL_LAST) begin
          next_state    = ST_IDLE;
          next_call_req = '0;
          if (call_req.high) begin
            next_in_high = 1'b1;
          end else begin
            next_in_low = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      call_cnt  <= 2'd0;
      call_req  <= '0;
      in_high   <= 1'b0;
      in_low    <= 1'b0;
      return_from_interrupt_hold <= 1'b0;
    end else begin
      state     <= next_state;
      call_cnt  <= next_call_cnt;
      call_req  <= next_call_req;
      in_high   <= next_in_high;
      in_low    <= next_in_low;
      return_from_interrupt_hold <= next_return_from_interrupt_hold;
    end
  end

  // ==========================================================================
  // Register writes, edge capture and read-back
  logic wr_timer_control_reg;
  logic vec0, vec1;
  assign wr_timer_control_reg = sfr.wr && (sfr.addr == ADDR_TIMER_CONTROL);
  assign vec0 = isr_enter && (call_req.index == 4'(SRC_EXT0));
  assign vec1 = isr_enter && (call_req.index == 4'(SRC_EXT1));

  always_comb begin
    next_int_en_main   = int_en_main;
    next_int_prio_main = int_prio_main;
    next_pin_cfg       = pin_cfg;
    next_int_en_ext    = int_en_ext;
    next_int_prio_ext  = int_prio_ext;
    next_edge0         = ext_irq_zero_edge_select;
    next_edge1         = ext_irq_one_edge_select;
    next_edge_flag0    = edge_flag0;
    next_edge_flag1    = edge_flag1;
    if (sfr.wr) begin
      unique case (sfr.addr)
        ADDR_INT_ENABLE_MAIN: next_int_en_main   = sfr.wdata;
        ADDR_INT_PRIO_MAIN:   next_int_prio_main = sfr.wdata;
        ADDR_EXT_PIN_CONFIG:  next_pin_cfg       = sfr.wdata;
        ADDR_INT_ENABLE_EXT:  next_int_en_ext    = sfr.wdata;
        ADDR_INT_PRIO_EXT:    next_int_prio_ext  = sfr.wdata;
        default: ;
      endcase
    end
    if (wr_timer_control_reg) begin
      next_edge0      = sfr.wdata[TIMER_CONTROL_REG_EDGE0_BIT];
      next_edge1      = sfr.wdata[TIMER_CONTROL_REG_EDGE1_BIT];
      next_edge_flag0 = sfr.wdata[TIMER_CONTROL_REG_PEND0_BIT];
      next_edge_flag1 = sfr.wdata[TIMER_CONTROL_REG_PEND1_BIT];
    end
    // Vectoring clears an edge flag
    if (vec0 && ext_irq_zero_edge_select) begin
      next_edge_flag0 = 1'b0;
    end
    if (vec1 && ext_irq_one_edge_select) begin
      next_edge_flag1 = 1'b0;
    end
    // A fresh edge in the clearing cycle is kept: set wins
    if (act0 && !act_prev0) begin
      next_edge_flag0 = 1'b1;
    end
    if (act1 && !act_prev1) begin
      next_edge_flag1 = 1'b1;
    end
    // Read data, registered for the next cycle
    next_rdata = 8'h00;
    if (sfr.rd) begin
      unique case (sfr.addr)
        ADDR_TIMER_CONTROL: begin
          next_rdata[TIMER_CONTROL_REG_EDGE0_BIT] = ext_irq_zero_edge_select;
          next_rdata[TIMER_CONTROL_REG_PEND0_BIT] = ext_irq_zero_pending;
          next_rdata[TIMER_CONTROL_REG_EDGE1_BIT] = ext_irq_one_edge_select;
          next_rdata[TIMER_CONTROL_REG_PEND1_BIT] = ext_irq_one_pending;
        end
        ADDR_INT_ENABLE_MAIN: next_rdata = int_en_main;
        ADDR_INT_PRIO_MAIN:   next_rdata = int_prio_main;
        ADDR_EXT_PIN_CONFIG:  next_rdata = pin_cfg;
        ADDR_INT_ENABLE_EXT:  next_rdata = int_en_ext;
        ADDR_INT_PRIO_EXT:    next_rdata = int_prio_ext;
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  // Priority bits reset to low for every source
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_en_main              <= RST_REG8;
      int_prio_main            <= RST_REG8;
      pin_cfg                  <= RST_REG8;
      int_en_ext               <= RST_REG8;
      int_prio_ext             <= RST_REG8;
      ext_irq_zero_edge_select <= 1'b0;
      ext_irq_one_edge_select  <= 1'b0;
      edge_flag0               <= 1'b0;
      edge_flag1               <= 1'b0;
      act_prev0                <= 1'b0;
      act_prev1                <= 1'b0;
      sfr_rdata                <= 8'h00;
    end else begin
      int_en_main              <= next_int_en_main;
      int_prio_main            <= next_int_prio_main;
      pin_cfg                  <= next_pin_cfg;
      int_en_ext               <= next_int_en_ext;
      int_prio_ext             <= next_int_prio_ext;
      ext_irq_zero_edge_select <= next_edge0;
      ext_irq_one_edge_select  <= next_edge1;
      edge_flag0               <= next_edge_flag0;
      edge_flag1               <= next_edge_flag1;
      act_prev0                <= act0;
      act_prev1                <= act1;
      sfr_rdata                <= next_rdata;
    end
  end

endmodule : eipl_ctrl

// >>> eipl_ctrl_assertions.sv
// Checker of call timing and routine nesting at the block's ports
`timescale 1ns/1ns
module eipl_ctrl_assertions
  import eipl_pkg::*;
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // Register side
  input wire eipl_sfr_t  sfr,
  input wire logic [7:0] sfr_rdata,
  // CPU side
  input wire logic       insn_boundary,
  input wire logic       return_from_interrupt_done,
  input wire eipl_req_t  call_req,
  input wire logic       call_active,
  input wire logic       isr_enter
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ========
  // Running levels, rebuilt from entries and returns
  logic hi_act, lo_act, next_hi_act, next_lo_act;
  always_comb begin
    next_hi_act = hi_act;
    next_lo_act = lo_act;
    if (return_from_interrupt_done && hi_act) next_hi_act = 1'b0;
    else if (return_from_interrupt_done) next_lo_act = 1'b0;
    if (isr_enter && call_req.high) next_hi_act = 1'b1;
    else if (isr_enter) next_lo_act = 1'b1;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) {hi_act, lo_act} <= 2'b00;
    else {hi_act, lo_act} <= {next_hi_act, next_lo_act};
  end
  // ========
  // Properties
  property p_call_len;
    $rose(call_active) |-> call_active[*4] ##1 !call_active;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call length");
  property p_enter_slot;
    $rose(call_active) |-> !isr_enter[*3] ##1 isr_enter;
  endproperty
  a_enter_slot: assert property (p_enter_slot) else $error("vector slot");
  property p_req_hold;
    call_active && $past(call_active) |-> $stable(call_req) && call_req.valid;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved");
  property p_boundary;
    $rose(call_active) |-> $past(insn_boundary) && !$past(return_from_interrupt_done);
  endproperty
  a_boundary: assert property (p_boundary) else $error("call mid insn");
  property p_return_from_interrupt_gap;
    return_from_interrupt_done |=> !call_active;
  endproperty
  a_return_from_interrupt_gap: assert property (p_return_from_interrupt_gap) else $error("call at return");
  property p_timer_control_reg_upper;
    $past(sfr.rd) && $past(sfr.addr) == ADDR_TIMER_CONTROL
      |-> sfr_rdata[7:4] == 4'h0;
  endproperty
  a_timer_control_reg_upper: assert property (p_timer_control_reg_upper) else $error("timer_control_reg high");
  property p_no_preempt;
    $rose(call_active) |-> !hi_act;
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("high cut");
  // A low routine lets only high requests in
  property p_low_blocks;
    $rose(call_active) && lo_act |-> call_req.high;
  endproperty
  a_low_blocks: assert property (p_low_blocks) else $error("low nest");
endmodule : eipl_ctrl_assertions

bind eipl_ctrl eipl_ctrl_assertions u_eipl_ctrl_assertions (
  .mclk(mclk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata),
  .insn_boundary(insn_boundary), .return_from_interrupt_done(return_from_interrupt_done),
  .call_req(call_req), .call_active(call_active), .isr_enter(isr_enter));

// >>> eipl_ctrl_tb_top.sv
// Self-checking bench of the interrupt priority block
`timescale 1ns/1ns
module eipl_ctrl_tb_top
  import eipl_pkg::*;
;
  logic               mclk, rst_n, slow, return_from_interrupt_go;
  logic               insn_boundary, return_from_interrupt_done, call_active, isr_enter;
  logic [7:0]         sfr_rdata, port_pins;
  logic [NUM_SRC-1:0] src_pending;
  eipl_sfr_t          sfr;
  eipl_req_t          call_req;
  int                 n_errors, checks_done, cyc, lat, k;
  // Rows: address, value written, value read back
  logic [7:0] rows [7][3] = '{
    '{ADDR_TIMER_CONTROL, 8'hF5, 8'h05}, '{ADDR_INT_ENABLE_MAIN, 8'h55, 8'h55},
    '{ADDR_INT_PRIO_MAIN, 8'hAA, 8'hAA}, '{ADDR_EXT_PIN_CONFIG, 8'h35, 8'h35},
    '{ADDR_INT_ENABLE_EXT, 8'hC3, 8'hC3}, '{ADDR_INT_PRIO_EXT, 8'h3C, 8'h3C},
    '{8'h99, 8'hFF, 8'h00}};
  eipl_ctrl u_eipl_ctrl (
    .mclk(mclk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .port_pins(port_pins), .src_pending(src_pending),
    .insn_boundary(insn_boundary), .return_from_interrupt_done(return_from_interrupt_done),
    .call_req(call_req), .call_active(call_active), .isr_enter(isr_enter));
  eipl_cpu_model u_eipl_cpu_model (
    .mclk(mclk), .rst_n(rst_n), .slow(slow), .return_from_interrupt_go(return_from_interrupt_go),
    .call_active(call_active), .insn_boundary(insn_boundary),
    .return_from_interrupt_done(return_from_interrupt_done));
  // ========
  // Tasks; every drive lands 1 ns after a rising edge
  task automatic finish_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step();
    @(posedge mclk) #1;
  endtask : step
  task automatic sfr_wr(input logic [7:0] a, d);
    step();
    sfr = '{1'b1, 1'b0, a, d};
    step();
    sfr = '0;
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, exp);
    step();
    sfr = '{1'b0, 1'b1, a, 8'h00};
    step();
    sfr = '0;
    check("register", sfr_rdata, exp);
  endtask : sfr_rd
  // No call may start for n cycles
  task automatic quiet(input int n);
    repeat (n) begin
      step();
      check("call_active", 8'(call_active), 8'h00);
    end
  endtask : quiet
  // Bounded wait for the vector, then the chosen source
  task automatic wait_enter(input logic [7:0] exp);
    lat = 0;
    while (isr_enter !== 1'b1 && lat < 60) begin
      step();
      lat++;
    end
    check("call_req", 8'(call_req), exp);
  endtask : wait_enter
  task automatic do_return_from_interrupt();
    return_from_interrupt_go = 1'b1;
    lat = 0;
    while (return_from_interrupt_done !== 1'b1 && lat < 40) begin
      step();
      lat++;
    end
    return_from_interrupt_go = 1'b0;
  endtask : do_return_from_interrupt
  // ========
  // Clock and hang guard; the run needs well under 2000 cycles
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    {rst_n, slow, return_from_interrupt_go} = 3'b000;
    sfr = '0;
    port_pins = 8'hFF;
    src_pending = '0;
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    for (k = 0; k < 7; k++) begin
      sfr_rd(rows[k][0], RST_REG8);
      sfr_wr(rows[k][0], rows[k][1]);
      sfr_rd(rows[k][0], rows[k][2]);
    end
    for (k = 1; k < 6; k++) sfr_wr(rows[k][0], RST_REG8);
    // Pin 3 active high edge, pin 6 active low level
    port_pins = 8'h40;
    sfr_wr(ADDR_EXT_PIN_CONFIG, 8'h6B);
    sfr_wr(ADDR_TIMER_CONTROL, 8'h01);
    port_pins[6] = 1'b0;
    repeat (2) step();
    sfr_rd(ADDR_TIMER_CONTROL, 8'h09);
    port_pins[6] = 1'b1;
    repeat (2) step();
    sfr_rd(ADDR_TIMER_CONTROL, 8'h01);
    port_pins = 8'hF7;
    repeat (2) step();
    sfr_rd(ADDR_TIMER_CONTROL, 8'h01);
    port_pins = 8'h40;
    // Edge latched while the global enable is off
    sfr_wr(ADDR_INT_ENABLE_MAIN, 8'h01);
    port_pins[3] = 1'b1;
    repeat (2) step();
    port_pins[3] = 1'b0;
    quiet(8);
    sfr_rd(ADDR_TIMER_CONTROL, 8'h03);
    sfr_wr(ADDR_TIMER_CONTROL, 8'h01);
    sfr_wr(ADDR_INT_ENABLE_MAIN, 8'h81);
    port_pins[3] = 1'b1;
    wait_enter(8'h20);
    check("latency", 8'(lat), 8'(MIN_RESPONSE));
    port_pins[3] = 1'b0;
    sfr_rd(ADDR_TIMER_CONTROL, 8'h01);
    // Nesting and preemption inside the low routine
    src_pending[1] = 1'b1;
    src_pending[5] = 1'b1;
    sfr_wr(ADDR_INT_ENABLE_MAIN, 8'hAB);
    quiet(8);
    sfr_wr(ADDR_INT_PRIO_MAIN, 8'h08);
    src_pending[3] = 1'b1;
    wait_enter(8'h33);
    src_pending[3] = 1'b0;
    sfr_wr(ADDR_INT_ENABLE_EXT, 8'h01);
    sfr_wr(ADDR_INT_PRIO_EXT, 8'h01);
    src_pending[7] = 1'b1;
    quiet(8);
    do_return_from_interrupt();
    wait_enter(8'h37);
    check("latency", 8'(lat), 8'(1 + CALL_CYCLES));
    src_pending[7] = 1'b0;
    slow = 1'b1;
    do_return_from_interrupt();
    quiet(12);
    do_return_from_interrupt();
    wait_enter(8'h21);
    check("latency", 8'(lat), 8'(MAX_RESPONSE - DETECT_CYCLES - RETURN_FROM_INTERRUPT_CYCLES));
    src_pending[1] = 1'b0;
    do_return_from_interrupt();
    wait_enter(8'h25);
    // Second reset in the last cycle of the call
    rst_n = 1'b0;
    step();
    check("call_active", 8'(call_active), 8'h00);
    rst_n = 1'b1;
    sfr_rd(ADDR_INT_PRIO_MAIN, RST_REG8);
    sfr_rd(ADDR_INT_PRIO_EXT, RST_REG8);
    // Low and high requests enabled in the same cycle: high goes first
    src_pending[1] = 1'b1;
    src_pending[3] = 1'b1;
    sfr_wr(ADDR_INT_PRIO_MAIN, 8'h08);
    sfr_wr(ADDR_INT_ENABLE_MAIN, 8'h8A);
    wait_enter(8'h33);
    finish_test();
  end
endmodule : eipl_ctrl_tb_top

// >>> eipl_pkg.sv
// Constants, register map and carrier types of the interrupt priority block
// Summary of operation
// - Edge-select 1 is edge, 0 is level; polarity 0 is active low, 1 high.
// - Each external input reads the pin its config names, undisturbed.
// - Pending flags zero and one sit at bits 1 and 3 of timer control.
// - An edge-mode pending flag clears when the CPU vectors to its routine.
// - A level-mode pending flag is 1 while the input is active, else 0.
// - Each source is low or high; high preempts low and is never preempted.
// - Every source has its own priority bit, reset to low priority.
// - Simultaneous requests go high first, ties by a fixed order.
// - All pending requests are sampled and decoded every clock cycle.
// - The shortest response is 5 cycles: detect 1, then long call 4.
// - After a return exactly one more instruction runs before the next call.
// - The worst response is 18 cycles: detect 1, return 5, divide 8, call 4.
// - Requests wait out an equal or higher routine, its return and one more.
package eipl_pkg;

  // ==========================================================================
  // Special function register addresses
  localparam logic [7:0] ADDR_TIMER_CONTROL   = 8'h88;
  localparam logic [7:0] ADDR_INT_ENABLE_MAIN = 8'hA8;
  localparam logic [7:0] ADDR_INT_PRIO_MAIN   = 8'hB8;
  localparam logic [7:0] ADDR_EXT_PIN_CONFIG  = 8'hE4;
  localparam logic [7:0] ADDR_INT_ENABLE_EXT  = 8'hE6;
  localparam logic [7:0] ADDR_INT_PRIO_EXT    = 8'hF6;

  // ==========================================================================
  // Field positions
  localparam int TIMER_CONTROL_REG_EDGE0_BIT = 0;
  localparam int TIMER_CONTROL_REG_PEND0_BIT = 1;
  localparam int TIMER_CONTROL_REG_EDGE1_BIT = 2;
  localparam int TIMER_CONTROL_REG_PEND1_BIT = 3;
  localparam int CFG_PIN0_LSB   = 0;
  localparam int CFG_POL0_BIT   = 3;
  localparam int CFG_PIN1_LSB   = 4;
  localparam int CFG_POL1_BIT   = 7;
  localparam int IE_GLOBAL_BIT  = 7;
  localparam int SRC_EXT0       = 0;
  localparam int SRC_EXT1       = 2;
  localparam int NUM_SRC        = 15;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_REG8 = 8'h00;

  // ==========================================================================
  // Response timing in clock cycles
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES   = 4;
  localparam int RETURN_FROM_INTERRUPT_CYCLES   = 5;
  localparam int DIV_CYCLES    = 8;
  localparam int MIN_RESPONSE  = DETECT_CYCLES + CALL_CYCLES;
  localparam int MAX_RESPONSE  = DETECT_CYCLES + RETURN_FROM_INTERRUPT_CYCLES + DIV_CYCLES
                                 + CALL_CYCLES;
  localparam logic [1:0] CALL_LAST = 2'(CALL_CYCLES - 1);

  // ==========================================================================
  // Types
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CALL = 1'b1
  } eipl_state_t;

  // Request handed to the CPU sequencer
  typedef struct packed {
    logic       valid;
    logic       high;
    logic [3:0] index;
  } eipl_req_t;

  // Register-side access from the CPU core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eipl_sfr_t;

endpackage : eipl_pkg
